// ---- rtl/agc_cs_ctrl.sv ----
`timescale 1ns/1ns
// Behaviour
// - Carrier sense after above_count plus one hits
// - Carrier sense clears after one or two misses
// - Gain change holds levels 16 to 48
// - Hold code seven freezes levels indefinitely
// - Switch, unlock, power-up start the gain hold
// - Those events also start a 16 to 128 converter clock hold
// - Floor bit picks lowest second amp gain
// - Ceiling bit picks highest second amp gain
// - Switch point picks gain step for amp
// - Floor one ceiling zero fixes amp gain
// - Auto off drives gain from start value
// - Double check needs two samples per step
// - Magnitude averaged over 2 to 16 samples
// - Five bit threshold sets carrier sense level
// - Start value loaded, gain above it clamped next cycle
module agc_cs_ctrl import agc_cs_pkg::*; (
  // Clock, reset, enable
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Wishbone slave
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  input  wire logic       we_i,
  input  wire logic [9:2] adr_i,
  input  wire logic [3:0] sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]     dat_o,
  output logic            ack_o,
  // Filter side, same clock
  input  wire logic       mag_valid,
  input  wire logic [4:0] mag_sample,
  input  wire logic       filter_tick,
  input  wire logic       adc_tick,
  // Pins from the analog side
  input  wire logic       freq_sel_pin,
  input  wire logic       pll_lock_pin,
  input  wire logic       rx_on_pin,
  // Gain and carrier outputs
  output logic            carrier_sense,
  output logic [4:0]      vga_gain,
  output logic [1:0]      amp2_gain,
  output logic            levels_frozen,
  output logic            irq
);

  // ==========================================================
  // Declarations
  cs_cfg_t    cs_cfg_q;       // Carrier sense and freeze setup
  gain_cfg_t  gain_cfg_q;     // Gain loop setup
  logic [4:0] start_q;        // Start and top gain
  logic [4:0] thresh_q;       // Carrier sense level
  logic [IRQ_W-1:0] stat_q;   // Sticky events
  logic [IRQ_W-1:0] en_q;     // Event enables
  logic [IRQ_W-1:0] evt_w;    // Events this cycle
  logic [IRQ_W-1:0] clr_w;    // Clear strobes
  logic       ack_q;          // Bus answer
  logic [31:0] dat_q;         // Read data
  logic       req_w;          // New bus access
  logic       wr_w;           // Write this cycle
  logic [2:0] s1_q;           // Sync first stage
  logic [2:0] s2_q;           // Sync second stage
  logic [2:0] s3_q;           // Edge history
  logic       restart_w;      // Switch, unlock or power-up
  logic       power_up_w;     // Receiver turned on
  logic       avg_valid;      // Average ready
  logic [4:0] avg_mag;        // Averaged magnitude
  logic       sample_ok_w;    // Average usable now
  logic       above_w;        // At or above level
  logic [1:0] above_run_q;    // Hits before this one
  logic       below_run_q;    // Misses before this one
  logic       cs_q;           // Carrier sense
  logic       cs_d;           // Next carrier sense
  logic [4:0] gain_q;         // Variable gain step
  logic [1:0] pend_q;         // Previous step request
  logic [1:0] req_step_w;     // Up is bit 0, down bit 1
  logic       step_w;         // Apply a step now
  logic       gain_chg_w;     // Gain moves this cycle
  logic       filt_busy;      // Filter clock hold
  logic       adc_busy;       // Converter clock hold
  logic       frozen_q;       // Delayed freeze
  amp2_gain_t amp2_q;         // Second amp gain
  amp2_gain_t amp2_d;         // Next second amp gain
  logic       amp2_hi_w;      // At or above switch point

  // ==========================================================
  // Address decode
  function automatic logic hit(input logic [9:2] a, input logic [7:0] idx);
    hit = (a == idx);
  endfunction

  // ==========================================================
  // Wishbone slave

  assign req_w = cyc_i & stb_i & ~ack_q;
  assign wr_w  = req_w & we_i & sel_i[0];

  // One wait state, ack drops after one cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= req_w;
    end
  end

  // Read data captured with the ack
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dat_q <= 32'h0000_0000;
    end else if (ce && req_w) begin
      dat_q <= 32'h0000_0000;
      // Unmapped words read as zero
      if (hit(adr_i, IDX_CS_CFG)) begin
        dat_q[7:0] <= cs_cfg_q;
      end else if (hit(adr_i, IDX_GAIN_CFG)) begin
        dat_q[7:0] <= gain_cfg_q;
      end else if (hit(adr_i, IDX_START)) begin
        dat_q[4:0] <= start_q;
      end else if (hit(adr_i, IDX_THRESH)) begin
        dat_q[4:0] <= thresh_q;
      end else if (hit(adr_i, IDX_IRQ_STAT)) begin
        dat_q[IRQ_W-1:0] <= stat_q;
      end else if (hit(adr_i, IDX_IRQ_EN)) begin
        dat_q[IRQ_W-1:0] <= en_q;
      end else if (hit(adr_i, IDX_STATE)) begin
        dat_q[8:0] <= {frozen_q, cs_q, amp2_q, gain_q};
      end
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ==========================================================
  // Configuration registers

  // Setup written from the bus
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cs_cfg_q   <= RST_CS_CFG;
      gain_cfg_q <= RST_GAIN_CFG;
      start_q    <= RST_START;
      thresh_q   <= RST_THRESH;
      en_q       <= '0;
    end else if (ce && wr_w) begin
      if (hit(adr_i, IDX_CS_CFG)) begin
        cs_cfg_q <= dat_i[7:0];
      end
      if (hit(adr_i, IDX_GAIN_CFG)) begin
        gain_cfg_q <= dat_i[7:0];
      end
      if (hit(adr_i, IDX_START)) begin
        start_q <= dat_i[4:0];
      end
      if (hit(adr_i, IDX_THRESH)) begin
        thresh_q <= dat_i[4:0];
      end
      if (hit(adr_i, IDX_IRQ_EN)) begin
        en_q <= dat_i[IRQ_W-1:0];
      end
    end
  end

  // ==========================================================
  // Interrupts

  assign clr_w = (wr_w && hit(adr_i, IDX_IRQ_CLR)) ? dat_i[IRQ_W-1:0] : '0;

  // Events gathered per source
  always_comb begin
    evt_w                = '0;
    evt_w[IRQ_CS_RISE]   = cs_d & ~cs_q;
    evt_w[IRQ_CS_FALL]   = ~cs_d & cs_q;
    evt_w[IRQ_GAIN_STEP] = gain_chg_w;
    evt_w[IRQ_HOLD_DONE] = frozen_q & ~levels_frozen;
  end

  // Sticky bits, a new event beats a clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat_q <= '0;
    end else if (ce) begin
      stat_q <= (stat_q & ~clr_w) | evt_w;
    end
  end

  assign irq = |(stat_q & en_q);

  // ==========================================================
  // Pin synchronisers and event edges

  // Two stages, then an edge history stage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end else if (ce) begin
      s1_q <= {rx_on_pin, pll_lock_pin, freq_sel_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign power_up_w = s2_q[2] & ~s3_q[2];
  // Frequency switch, lock loss or power-up
  assign restart_w  = (s2_q[0] ^ s3_q[0]) | (s3_q[1] & ~s2_q[1]) | power_up_w;

  // ==========================================================
  // Magnitude averaging
  mag_averager u_avg (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (mag_valid),
    .in_mag    (mag_sample),
    .avg_len   (gain_cfg_q.avg_len),
    .out_valid (avg_valid),
    .out_mag   (avg_mag)
  );

  // Frozen levels ignore new averages
  assign sample_ok_w = avg_valid & ~levels_frozen;
  assign above_w     = avg_mag >= thresh_q;

  // ==========================================================
  // Carrier sense qualification

  // Next carrier sense from run lengths
  always_comb begin
    cs_d = cs_q;
    if (sample_ok_w) begin
      if (above_w && above_run_q >= cs_cfg_q.above_cnt) begin
        cs_d = 1'b1;
      end else if (!above_w && below_run_q >= cs_cfg_q.below_cnt) begin
        cs_d = 1'b0;
      end
    end
  end

  // Consecutive run counters
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      above_run_q <= 2'h0;
      below_run_q <= 1'b0;
      cs_q        <= 1'b0;
    end else if (ce) begin
      cs_q <= cs_d;
      if (sample_ok_w) begin
        if (above_w) begin
          // Saturates at the longest run
          above_run_q <= (above_run_q == 2'h3) ? 2'h3 : above_run_q + 2'h1;
          below_run_q <= 1'b0;
        end else begin
          above_run_q <= 2'h0;
          below_run_q <= 1'b1;
        end
      end
    end
  end

  assign carrier_sense = cs_q;

  // ==========================================================
  // Gain loop

  // Up when weak, down when strong
  always_comb begin
    req_step_w = 2'h0;
    if (sample_ok_w) begin
      if (avg_mag < thresh_q && gain_q < start_q) begin
        req_step_w = 2'h1;
      end else if (avg_mag > thresh_q && gain_q != 5'h00) begin
        req_step_w = 2'h2;
      end
    end
  end

  // Second request must match the first
  assign step_w = (req_step_w != 2'h0) && !gain_cfg_q.auto_off &&
                  (!gain_cfg_q.dbl_check || pend_q == req_step_w);

  // Remember the last request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend_q <= 2'h0;
    end else if (ce && sample_ok_w) begin
      pend_q <= step_w ? 2'h0 : req_step_w;
    end
  end

  assign gain_chg_w = step_w & ~restart_w;

  // Gain step register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gain_q <= RST_START;
    end else if (ce) begin
      if (gain_cfg_q.auto_off || power_up_w || restart_w) begin
        gain_q <= start_q;
      end else if (gain_q > start_q) begin
        gain_q <= start_q;
      end else if (step_w) begin
        gain_q <= req_step_w[0] ? gain_q + 5'h01 : gain_q - 5'h01;
      end
    end
  end

  assign vga_gain = gain_q;

  // ==========================================================
  // Freeze timers

  // Filter clock hold after a gain step or a restart
  hold_timer u_filt_hold (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .ce           (ce),
    .start        (gain_chg_w | restart_w),
    .load         (gain_hold_clks(cs_cfg_q.gain_hold)),
    .forever_hold (cs_cfg_q.gain_hold == HOLD_FOREVER),
    .tick         (filter_tick),
    .busy         (filt_busy)
  );

  // Extra converter clock hold on restart
  hold_timer u_adc_hold (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .ce           (ce),
    .start        (restart_w),
    .load         (EXTRA_HOLD_BASE << cs_cfg_q.extra_hold),
    .forever_hold (1'b0),
    .tick         (adc_tick),
    .busy         (adc_busy)
  );

  assign levels_frozen = filt_busy | adc_busy;

  // Freeze history for the release event
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      frozen_q <= 1'b0;
    end else if (ce) begin
      frozen_q <= levels_frozen;
    end
  end

  // ==========================================================
  // Second amplifier gain

  // Switch point against the gain step
  always_comb begin
    case (gain_cfg_q.switch_pt)
      2'h0:    amp2_hi_w = 1'b1;
      2'h1:    amp2_hi_w = gain_q >= SWITCH_STEP_LO;
      2'h2:    amp2_hi_w = gain_q >= SWITCH_STEP_HI;
      default: amp2_hi_w = 1'b0;
    endcase
  end

  // Bounded choice or fixed setting
  always_comb begin
    if (gain_cfg_q.amp2_floor && !gain_cfg_q.amp2_ceil) begin
      case (gain_cfg_q.switch_pt)
        2'h0:    amp2_d = AMP2_MID_HI;
        2'h1:    amp2_d = AMP2_MIN;
        2'h2:    amp2_d = AMP2_MED;
        default: amp2_d = AMP2_MAX;
      endcase
    end else if (amp2_hi_w) begin
      amp2_d = gain_cfg_q.amp2_ceil ? AMP2_MAX : AMP2_MED;
    end else begin
      amp2_d = gain_cfg_q.amp2_floor ? AMP2_MED : AMP2_MIN;
    end
  end

  // Registered amp gain
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      amp2_q <= AMP2_MED;
    end else if (ce) begin
      amp2_q <= amp2_d;
    end
  end

  assign amp2_gain = amp2_q;

  // ==========================================================
  // Checks

  a_cs_rise_run: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(cs_q) |-> $past(above_run_q) >= $past(cs_cfg_q.above_cnt) && $past(sample_ok_w))
    else $error("carrier sense rose too soon");

  a_cs_fall_run: assert property (
    @(posedge sys_clk) disable iff (rst)
    $fell(cs_q) |-> $past(below_run_q) >= $past(cs_cfg_q.below_cnt) && !$past(above_w))
    else $error("carrier sense fell too soon");

  a_gain_step_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && gain_chg_w) |=> levels_frozen ##1 levels_frozen)
    else $error("no hold after gain change");

  a_hold_forever: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && filt_busy && cs_cfg_q.gain_hold == HOLD_FOREVER && !wr_w) |=> levels_frozen)
    else $error("open ended hold released");

  a_restart_freeze: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && restart_w) |=> adc_busy && filt_busy && vga_gain == $past(start_q))
    else $error("restart did not freeze levels");

  a_amp2_bounds: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && !(gain_cfg_q.amp2_floor && !gain_cfg_q.amp2_ceil)) |=>
      amp2_q >= ($past(gain_cfg_q.amp2_floor) ? AMP2_MED : AMP2_MIN) &&
      amp2_q <= ($past(gain_cfg_q.amp2_ceil) ? AMP2_MAX : AMP2_MED))
    else $error("second amp gain out of bounds");

  a_auto_off_gain: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && gain_cfg_q.auto_off) |=> vga_gain == $past(start_q))
    else $error("gain not taken from start value");

  a_gain_ceiling: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce |=> vga_gain <= $past(start_q))
    else $error("gain above start value");

  a_freeze_blocks: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && levels_frozen && !restart_w) |=> vga_gain == $past(vga_gain) || $past(gain_cfg_q.auto_off))
    else $error("gain moved while frozen");

endmodule

// ---- rtl/agc_cs_pkg.sv ----
// ==========================================================
// Shared constants and types
package agc_cs_pkg;

  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_CS_CFG   = 8'h11;  // Carrier sense and freeze
  localparam logic [7:0] IDX_GAIN_CFG = 8'h12;  // Gain loop
  localparam logic [7:0] IDX_START    = 8'h13;  // Start and top gain
  localparam logic [7:0] IDX_THRESH   = 8'h14;  // Signal threshold
  localparam logic [7:0] IDX_IRQ_STAT = 8'h20;  // Sticky events, read only
  localparam logic [7:0] IDX_IRQ_CLR  = 8'h21;  // Write one to clear
  localparam logic [7:0] IDX_IRQ_EN   = 8'h22;  // Interrupt enables
  localparam logic [7:0] IDX_STATE    = 8'h23;  // Live block state

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_CS_CFG   = 8'h65;
  localparam logic [7:0] RST_GAIN_CFG = 8'h75;
  localparam logic [4:0] RST_START    = 5'h18;
  localparam logic [4:0] RST_THRESH   = 5'h18;

  // ==========================================================
  // Field layouts
  typedef struct packed {
    logic [1:0] above_cnt;   // Samples above, minus one
    logic       below_cnt;   // Samples below, minus one
    logic [2:0] gain_hold;   // Filter clock hold code
    logic [1:0] extra_hold;  // Converter clock hold code
  } cs_cfg_t;

  typedef struct packed {
    logic       amp2_floor;  // Lowest second amp gain
    logic       amp2_ceil;   // Highest second amp gain
    logic [1:0] switch_pt;   // Second amp switch point
    logic       auto_off;    // Automatic gain stopped
    logic       dbl_check;   // Two samples per small step
    logic [1:0] avg_len;     // Averaging length code
  } gain_cfg_t;

  // Second amp gain codes
  typedef enum logic [1:0] {
    AMP2_MIN    = 2'h0,
    AMP2_MED    = 2'h1,
    AMP2_MAX    = 2'h2,
    AMP2_MID_HI = 2'h3
  } amp2_gain_t;

  // ==========================================================
  // Timing and steps
  localparam logic [2:0] HOLD_FOREVER    = 3'h7;
  localparam logic [7:0] EXTRA_HOLD_BASE = 8'h10;
  localparam logic [4:0] SWITCH_STEP_LO  = 5'h0a;
  localparam logic [4:0] SWITCH_STEP_HI  = 5'h13;
  localparam int         IRQ_W           = 4;
  localparam int         IRQ_CS_RISE     = 0;
  localparam int         IRQ_CS_FALL     = 1;
  localparam int         IRQ_GAIN_STEP   = 2;
  localparam int         IRQ_HOLD_DONE   = 3;

  // Filter clocks held after a gain change
  function automatic logic [7:0] gain_hold_clks(input logic [2:0] code);
    case (code)
      3'h0:    gain_hold_clks = 8'h10;
      3'h1:    gain_hold_clks = 8'h14;
      3'h2:    gain_hold_clks = 8'h18;
      3'h3:    gain_hold_clks = 8'h1c;
      3'h4:    gain_hold_clks = 8'h20;
      3'h5:    gain_hold_clks = 8'h28;
      default: gain_hold_clks = 8'h30;
    endcase
  endfunction

endpackage

// ---- rtl/hold_timer.sv ----
`timescale 1ns/1ns
// ==========================================================
// Tick counting hold timer
module hold_timer import agc_cs_pkg::*; (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Control
  input  wire logic       start,
  input  wire logic [7:0] load,
  input  wire logic       forever_hold,
  input  wire logic       tick,
  // Status
  output logic            busy
);

  logic [7:0] cnt_q;     // Ticks left
  logic       forever_q; // Open ended hold

  // Count down on ticks
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
    end else if (ce) begin
      if (start) begin
        cnt_q <= load;
      end else if (tick && cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  // Open ended hold lasts while its code stays
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      forever_q <= 1'b0;
    end else if (ce) begin
      forever_q <= start ? forever_hold : (forever_q & forever_hold);
    end
  end

  assign busy = (cnt_q != 8'h00) | forever_q;

  // Never releases early
  a_hold_early_end: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && !start && cnt_q > 8'h01) |=> busy && cnt_q >= $past(cnt_q) - 8'h01)
    else $error("hold timer released early");

endmodule

// ---- rtl/mag_averager.sv ----
`timescale 1ns/1ns
// ==========================================================
// Block average of magnitude samples
module mag_averager import agc_cs_pkg::*; (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Samples in
  input  wire logic       in_valid,
  input  wire logic [4:0] in_mag,
  input  wire logic [1:0] avg_len,
  // Averages out
  output logic            out_valid,
  output logic [4:0]      out_mag
);

  logic [8:0] acc_q;   // Running sum
  logic [3:0] cnt_q;   // Samples taken
  logic [3:0] last_w;  // Index of final sample
  logic [8:0] sum_w;   // Sum with this sample

  assign last_w = 4'((5'h02 << avg_len) - 5'h01);
  assign sum_w  = acc_q + {4'h0, in_mag};

  // Accumulate and emit one average per block
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_q     <= 9'h000;
      cnt_q     <= 4'h0;
      out_valid <= 1'b0;
      out_mag   <= 5'h00;
    end else if (ce) begin
      out_valid <= 1'b0;
      if (in_valid) begin
        if (cnt_q >= last_w) begin
          acc_q     <= 9'h000;
          cnt_q     <= 4'h0;
          out_valid <= 1'b1;
          out_mag   <= 5'(sum_w >> ({1'b0, avg_len} + 3'h1));
        end else begin
          acc_q <= sum_w;
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end

  // An average always closes a counted block
  a_avg_block_end: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && in_valid && cnt_q == last_w) |=> out_valid && cnt_q == 4'h0)
    else $error("average not emitted at block end");

endmodule

// ---- verification/analog_side_model.sv ----
`timescale 1ns/1ns
// ==========================================================
// Analog side: magnitude samples and clock ticks
module analog_side_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Level to present
  input  wire logic [4:0] level,
  // Toward the block
  output logic            mag_valid,
  output logic [4:0]      mag_sample,
  output logic            filter_tick,
  output logic            adc_tick
);
  logic [1:0] ph_q;  // Phase of the tick pattern
  // Free running phase
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) ph_q <= 2'h0;
    else ph_q <= ph_q + 2'h1;
  end
  assign mag_valid   = (ph_q == 2'h1);
  assign mag_sample  = mag_valid ? level : ~level;  // Stale value never shown
  assign filter_tick = (ph_q == 2'h3);
  assign adc_tick    = ph_q[0];
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/1ns
// ==========================================================
// Gain and carrier block bench
module testbench import agc_cs_pkg::*;;
  logic        sys_clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, rx_on = 1'b0, lock = 1'b1, fsel = 1'b0;
  logic        ack_o, mag_valid, ftick, atick, carrier, frozen, irq;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, dat_o, rd;
  logic [4:0]  level = 5'h00, mag, gain;
  logic [1:0]  amp2;
  int          fails = 0, comparisons = 0;
  // Reset values, second amp cases, hold lengths
  logic [7:0]  ri [6] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h22, 8'h30};
  logic [7:0]  re [6] = '{8'h65, 8'h75, 8'h18, 8'h18, 8'h00, 8'h00};
  logic [7:0]  ac [9] = '{8'h8c, 8'h9c, 8'hac, 8'hbc, 8'h4c, 8'h0c, 8'hfc, 8'h5c, 8'h7c};
  logic [1:0]  ae [9] = '{AMP2_MID_HI, AMP2_MIN, AMP2_MED, AMP2_MAX, AMP2_MAX, AMP2_MED, AMP2_MED, AMP2_MAX, AMP2_MIN};
  int          hl [7] = '{16, 20, 24, 28, 32, 40, 48};

  agc_cs_ctrl i_dut (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'h1), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .mag_valid(mag_valid), .mag_sample(mag),
    .filter_tick(ftick), .adc_tick(atick), .freq_sel_pin(fsel), .pll_lock_pin(lock), .rx_on_pin(rx_on),
    .carrier_sense(carrier), .vga_gain(gain), .amp2_gain(amp2), .levels_frozen(frozen), .irq(irq));
  analog_side_model i_far (.sys_clk(sys_clk), .rst(rst), .level(level), .mag_valid(mag_valid),
    .mag_sample(mag), .filter_tick(ftick), .adc_tick(atick));

  // Clock and watchdog
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    tally_and_finish();
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Classic single cycle, held until ack, then one idle cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Let k samples pass, then settle
  task automatic wait_smp(input int k);
    int n;
    repeat (k) begin
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (mag_valid !== 1'b1 && n < 9);
      if (n >= 9) begin
        fails++;
        tally_and_finish();
      end
    end
    repeat (3) @(posedge sys_clk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    int i, n, f, a;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("amp2 reset", AMP2_MED, amp2);
    for (i = 0; i < 6; i++) begin
      xfer(1'b0, ri[i], 32'h0);
      chk("reset read", re[i], rd);
    end
    xfer(1'b1, IDX_IRQ_STAT, 32'hf);
    xfer(1'b0, IDX_IRQ_STAT, 32'h0);
    chk("status", 32'h0, rd);
    // Second amp selection cases
    for (i = 0; i < 9; i++) begin
      xfer(1'b1, IDX_GAIN_CFG, {24'h0, ac[i]});
      repeat (3) @(posedge sys_clk);
      chk("amp2", ae[i], amp2);
    end
    xfer(1'b1, IDX_START, 32'h11);
    repeat (3) @(posedge sys_clk);
    chk("gain", 32'h11, gain);
    xfer(1'b1, IDX_START, 32'h18);
    xfer(1'b1, IDX_IRQ_EN, 32'h3);
    // Carrier sense counts, interrupt raise, clear, mask
    for (i = 0; i < 4; i++) begin
      xfer(1'b1, IDX_CS_CFG, {24'h0, i[1:0], i[0], 5'h00});
      level <= 5'h18;
      wait_smp(2 * i + 1);
      chk("carrier early", 32'h0, carrier);
      wait_smp(2);
      chk("carrier", 32'h1, carrier);
      chk("irq rise", 32'h1, irq);
      xfer(1'b1, IDX_IRQ_CLR, 32'hf);
      chk("irq clear", 32'h0, irq);
      level <= 5'h00;
      wait_smp(1);
      if (i[0]) chk("carrier kept", 32'h1, carrier);
      wait_smp(1 + 2 * i[0]);
      chk("carrier off", 32'h0, carrier);
      chk("irq fall", 32'h1, irq);
      xfer(1'b1, IDX_IRQ_EN, 32'h0);
      chk("irq mask", 32'h0, irq);
      xfer(1'b1, IDX_IRQ_EN, 32'h3);
      xfer(1'b1, IDX_IRQ_CLR, 32'hf);
    end
    // Automatic gain with double check
    xfer(1'b1, IDX_GAIN_CFG, 32'h74);
    level <= 5'h1f;
    wait_smp(3);
    chk("gain held", 32'h18, gain);
    for (n = 0; n < 300 && gain === 5'h18; n++) @(posedge sys_clk);
    chk("gain step", 32'h17, gain);
    @(posedge sys_clk);
    chk("frozen", 32'h1, frozen);
    level <= 5'h00;
    repeat (600) @(posedge sys_clk);
    chk("gain top", 32'h18, gain);
    xfer(1'b0, IDX_STATE, 32'h0);
    chk("state", 32'h18, rd);
    xfer(1'b1, IDX_GAIN_CFG, 32'h7c);
    // Freeze lengths after pin events
    for (i = 0; i < 7; i++) begin
      xfer(1'b1, IDX_CS_CFG, {24'h0, 3'h0, i[2:0], i[1:0]});
      case (i % 3)
        0: rx_on <= 1'b1;
        1: lock <= 1'b0;
        default: fsel <= ~fsel;
      endcase
      n = 0;
      f = 0;
      a = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (frozen !== 1'b1 && n < 8);
      chk("frozen", 32'h1, frozen);
      for (n = 0; n < 900 && frozen === 1'b1; n++) begin
        @(posedge sys_clk);
        f += ftick;
        a += atick;
      end
      chk("filter ticks", 32'h1, f + 1 >= hl[i]);
      chk("adc ticks", 32'h1, a + 1 >= (16 << i[1:0]));
      chk("release", 32'h1, f <= hl[i] + 1 || a <= (16 << i[1:0]) + 1);
      rx_on <= 1'b0;
      lock <= 1'b1;
    end
    xfer(1'b1, IDX_CS_CFG, 32'h1c);
    rx_on <= 1'b1;
    repeat (400) @(posedge sys_clk);
    chk("frozen forever", 32'h1, frozen);
    xfer(1'b1, IDX_CS_CFG, 32'h00);
    for (n = 0; n < 300 && frozen === 1'b1; n++) @(posedge sys_clk);
    chk("frozen end", 32'h0, frozen);
    tally_and_finish();
  end
endmodule
